// >>> design/hvwk_pkg.sv
package hvwk_pkg;

    // =========================================================================
    // register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] ADDR_WAKE_ENABLE  = 8'h00;
    localparam logic [7:0] ADDR_CURRENT_SRC  = 8'h04;
    localparam logic [7:0] ADDR_DETECT_FILT  = 8'h08;
    localparam logic [7:0] ADDR_WAKE_SOURCE  = 8'h0c;
    localparam logic [7:0] ADDR_LEVEL_STAT   = 8'h10;
    localparam logic [7:0] ADDR_ALT_WAKE     = 8'h14;
    localparam logic [7:0] ADDR_MODE_CTRL    = 8'h18;

    localparam int N_WAKE = 3;
    localparam int N_ALT  = 2;

    // =========================================================================
    // field positions and reset values
    localparam int MODE_LSB  = 0;
    localparam int ALT_EN_LSB = 2;
    localparam logic [2:0] RST_WAKE_EN = 3'h0;
    localparam logic [5:0] RST_CURSRC  = 6'h00;
    localparam logic [5:0] RST_DETECT  = 6'h00;
    localparam logic [1:0] RST_ALT_EN  = 2'h0;

    // =========================================================================
    // codes
    typedef enum logic [1:0] {
        HVWK_MODE_NORMAL,
        HVWK_MODE_STOP,
        HVWK_MODE_SLEEP,
        HVWK_MODE_FAILSAFE
    } hvwk_mode_t;

    localparam logic [1:0] CUR_NONE = 2'h0;
    localparam logic [1:0] CUR_DOWN = 2'h1;
    localparam logic [1:0] CUR_UP   = 2'h2;
    localparam logic [1:0] CUR_AUTO = 2'h3;

    localparam logic [1:0] DET_STATIC16 = 2'h0;
    localparam logic [1:0] DET_STATIC64 = 2'h1;
    localparam logic [1:0] DET_CYCLIC1  = 2'h2;
    localparam logic [1:0] DET_CYCLIC2  = 2'h3;

    // =========================================================================
    // timing at 20 MHz
    localparam int CLK_HZ        = 20000000;
    localparam int FILT_SHORT_US = 16;
    localparam int FILT_LONG_US  = 64;
    localparam int FILT_SHORT_CYC = (FILT_SHORT_US * (CLK_HZ / 1000000) > 0)
                                    ? FILT_SHORT_US * (CLK_HZ / 1000000) : 1;
    localparam int FILT_LONG_CYC  = (FILT_LONG_US * (CLK_HZ / 1000000) > 0)
                                    ? FILT_LONG_US * (CLK_HZ / 1000000) : 1;
    localparam int FILT_W = 11;

endpackage : hvwk_pkg

// >>> design/hvwk_filter.sv
`timescale 1ns/1ps

// one wake input: synchroniser, both-edge detect and deglitch filter
module hvwk_filter
(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      pin,
    input  wire logic                      active,
    input  wire logic [hvwk_pkg::FILT_W-1:0] filt_len,
    output logic                           level,
    output logic                           event_pulse
);
    import hvwk_pkg::*;

    typedef struct packed {
        logic              sync_a;
        logic              sync_b;
        logic              stable;
        logic              pending;
        logic [FILT_W-1:0] count;
        logic              evt;
    } hvwk_filt_state_t;

    hvwk_filt_state_t state;
    hvwk_filt_state_t next_state;

    always_comb
    begin
        next_state        = state;
        next_state.sync_a = pin;
        next_state.sync_b = state.sync_a;
        next_state.evt    = 1'b0;
        if (!active)
        begin
            // outside the sensing window the level is frozen
            next_state.pending = 1'b0;
            next_state.count   = '0;
        end
        else if (state.sync_b == state.stable)
        begin
            // a re-crossing before expiry discards the candidate
            next_state.pending = 1'b0;
            next_state.count   = '0;
        end
        else if (!state.pending)
        begin
            next_state.pending = 1'b1;
            next_state.count   = FILT_W'(1);
        end
        else if (state.count >= filt_len)
        begin
            next_state.stable  = state.sync_b;
            next_state.pending = 1'b0;
            next_state.evt     = 1'b1;
        end
        else
        begin
            next_state.count = state.count + FILT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= '0;
        else
            state <= next_state;
    end

    assign level       = state.stable;
    assign event_pulse = state.evt;

endmodule : hvwk_filter

// >>> design/hvwk_monitor.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

// =============================================================================
// Functional notes
// - report wake on rising and falling edges
// - interrupt in normal/stop, wake in sleep/failsafe
// - static or cyclic sensing per input
// - accept only if stable through filter
// - per-input software wake enable
// - sticky per-input wake flags, always readable
// - level status readable in normal and stop
// - cyclic level is last window sample
// - alt pins: fixed 16us, separate status
// - current select: none, down, up, auto
// - auto mode follows detected input level
// - detect field: static16, static64, cyclic1, cyclic2
module hvwk_monitor
(
    input  wire logic                   REF_CLK,
    input  wire logic                   NRST,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [7:0]             PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic [hvwk_pkg::N_WAKE-1:0] WAKE_PIN,
    input  wire logic [hvwk_pkg::N_ALT-1:0]  ALT_OUTPUT_PIN,
    input  wire logic                   CYCLIC_WINDOW_ONE,
    input  wire logic                   CYCLIC_WINDOW_TWO,
    output logic      [hvwk_pkg::N_WAKE-1:0] PULL_UP_EN,
    output logic      [hvwk_pkg::N_WAKE-1:0] PULL_DOWN_EN,
    output logic                        WAKE_INTERRUPT,
    output logic                        WAKE_REQUEST
);
    import hvwk_pkg::*;

    // =========================================================================
    // state
    // every register and registered output lives in this one word
    typedef struct packed {
        logic [N_WAKE-1:0]   wake_enable;
        logic [2*N_WAKE-1:0] current_src;
        logic [2*N_WAKE-1:0] detect;
        logic [N_ALT-1:0]    alt_enable;
        hvwk_mode_t          mode;
        logic [N_WAKE-1:0]   wake_flag;
        logic [N_ALT-1:0]    alt_flag;
        logic                irq;
        logic                wake_req;
        logic [N_WAKE-1:0]   pull_up;
        logic [N_WAKE-1:0]   pull_down;
        logic [31:0]         rdata;
        logic                slverr;
    } hvwk_state_t;

    hvwk_state_t state;
    hvwk_state_t next_state;

    logic [N_WAKE-1:0] level;
    logic [N_WAKE-1:0] wake_evt;
    logic [N_WAKE-1:0] active;
    logic [N_ALT-1:0]  alt_level;
    logic [N_ALT-1:0]  alt_evt;
    logic              wr_en;
    logic              rd_en;
    logic              addr_known;

    // window inputs come from another block on this clock, so no sync needed
    always_comb
    begin
        for (int i = 0; i < N_WAKE; i++)
        begin
            case (state.detect[2*i +: 2])
                DET_CYCLIC1: active[i] = CYCLIC_WINDOW_ONE;
                DET_CYCLIC2: active[i] = CYCLIC_WINDOW_TWO;
                default:     active[i] = 1'b1;
            endcase
        end
    end

    // =========================================================================
    // filter instances
    genvar g;
    generate
        for (g = 0; g < N_WAKE; g++)
        begin : g_wake
            logic [FILT_W-1:0] len;
            // 64us only for static-long; cyclic settings also use 16us
            assign len = (state.detect[2*g +: 2] == DET_STATIC64)
                         ? FILT_W'(FILT_LONG_CYC) : FILT_W'(FILT_SHORT_CYC);
            hvwk_filter u_filt
            (
                .clk         (REF_CLK),
                .nrst        (NRST),
                .pin         (WAKE_PIN[g]),
                .active      (active[g]),
                .filt_len    (len),
                .level       (level[g]),
                .event_pulse (wake_evt[g])
            );
        end
        // alt pins only sense while enabled and always use the short filter
        for (g = 0; g < N_ALT; g++)
        begin : g_alt
            hvwk_filter u_filt
            (
                .clk         (REF_CLK),
                .nrst        (NRST),
                .pin         (ALT_OUTPUT_PIN[g]),
                .active      (state.alt_enable[g]),
                .filt_len    (FILT_W'(FILT_SHORT_CYC)),
                .level       (alt_level[g]),
                .event_pulse (alt_evt[g])
            );
        end
    endgenerate

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;

    // =========================================================================
    // address decode
    // zero wait states: a write lands at the access edge, and read data is
    // captured at the setup edge so that it stands through the access phase
    always_comb
    begin
        if (PADDR == ADDR_WAKE_ENABLE)
            addr_known = 1'b1;
        else if (PADDR == ADDR_CURRENT_SRC)
            addr_known = 1'b1;
        else if (PADDR == ADDR_DETECT_FILT)
            addr_known = 1'b1;
        else if (PADDR == ADDR_WAKE_SOURCE)
            addr_known = 1'b1;
        else if (PADDR == ADDR_LEVEL_STAT)
            addr_known = 1'b1;
        else if (PADDR == ADDR_ALT_WAKE)
            addr_known = 1'b1;
        else if (PADDR == ADDR_MODE_CTRL)
            addr_known = 1'b1;
        else
            addr_known = 1'b0;
    end

    // =========================================================================
    // next state
    always_comb
    begin
        logic [N_WAKE-1:0] clr_w;
        logic [N_ALT-1:0]  clr_a;
        logic [N_WAKE-1:0] hit;
        logic [N_ALT-1:0]  alt_hit;
        logic              low_power;
        next_state = state;
        clr_w      = '0;
        clr_a      = '0;
        hit        = '0;
        alt_hit    = '0;
        low_power  = 1'b0;

        // ---- register writes ----
        next_state.slverr = 1'b0;
        if (wr_en)
        begin
            if (PADDR == ADDR_WAKE_ENABLE)
                next_state.wake_enable = PWDATA[N_WAKE-1:0];
            else if (PADDR == ADDR_CURRENT_SRC)
                next_state.current_src = PWDATA[2*N_WAKE-1:0];
            else if (PADDR == ADDR_DETECT_FILT)
                next_state.detect = PWDATA[2*N_WAKE-1:0];
            else if (PADDR == ADDR_WAKE_SOURCE)
                clr_w = PWDATA[N_WAKE-1:0];  // write one to clear
            else if (PADDR == ADDR_ALT_WAKE)
                clr_a = PWDATA[N_ALT-1:0];
            else if (PADDR == ADDR_MODE_CTRL)
            begin
                next_state.mode       = hvwk_mode_t'(PWDATA[MODE_LSB +: 2]);
                next_state.alt_enable = PWDATA[ALT_EN_LSB +: N_ALT];
            end
            else if (PADDR != ADDR_LEVEL_STAT)
                next_state.slverr = 1'b1;
        end

        // ---- wake flags: a new event wins over a same-cycle clear ----
        hit     = wake_evt & state.wake_enable;
        alt_hit = alt_evt;
        next_state.wake_flag = (state.wake_flag & ~clr_w) | hit;
        next_state.alt_flag  = (state.alt_flag & ~clr_a) | alt_hit;

        // ---- interrupt or wake, by mode ----
        low_power = (state.mode == HVWK_MODE_SLEEP)
                    || (state.mode == HVWK_MODE_FAILSAFE);
        // level outputs follow the sticky flags so software sees the cause
        next_state.irq      = !low_power
                              && ((next_state.wake_flag != '0)
                              || (next_state.alt_flag != '0));
        next_state.wake_req = low_power
                              && ((next_state.wake_flag != '0)
                              || (next_state.alt_flag != '0));

        // ---- current sources ----
        // auto switching follows the filtered level, so a short glitch cannot
        // flip the source and then hold the pin across the threshold itself
        for (int i = 0; i < N_WAKE; i++)
        begin
            case (state.current_src[2*i +: 2])
                CUR_DOWN:
                begin
                    next_state.pull_up[i]   = 1'b0;
                    next_state.pull_down[i] = 1'b1;
                end
                CUR_UP:
                begin
                    next_state.pull_up[i]   = 1'b1;
                    next_state.pull_down[i] = 1'b0;
                end
                CUR_AUTO:
                begin
                    next_state.pull_up[i]   = level[i];
                    next_state.pull_down[i] = !level[i];
                end
                default:
                begin
                    next_state.pull_up[i]   = 1'b0;
                    next_state.pull_down[i] = 1'b0;
                end
            endcase
        end

        // ---- read data, latched in the setup cycle ----
        if (rd_en)
        begin
            next_state.rdata = '0;
            if (PADDR == ADDR_WAKE_ENABLE)
                next_state.rdata[N_WAKE-1:0] = state.wake_enable;
            else if (PADDR == ADDR_CURRENT_SRC)
                next_state.rdata[2*N_WAKE-1:0] = state.current_src;
            else if (PADDR == ADDR_DETECT_FILT)
                next_state.rdata[2*N_WAKE-1:0] = state.detect;
            else if (PADDR == ADDR_WAKE_SOURCE)
                next_state.rdata[N_WAKE-1:0] = state.wake_flag;
            else if (PADDR == ADDR_LEVEL_STAT)
            begin
                // levels are only meaningful in normal and stop
                if (!low_power)
                    next_state.rdata[N_WAKE-1:0] = level;
            end
            else if (PADDR == ADDR_ALT_WAKE)
                next_state.rdata[N_ALT-1:0] = state.alt_flag;
            else if (PADDR == ADDR_MODE_CTRL)
            begin
                next_state.rdata[MODE_LSB +: 2]       = state.mode;
                next_state.rdata[ALT_EN_LSB +: N_ALT] = state.alt_enable;
            end
        end
        else if (PSEL && !PENABLE)
        begin
            // a write setup clears any stale read data
            next_state.rdata = '0;
        end
        if (PSEL && !PENABLE && !PWRITE)
        begin
            // unmapped reads answer with an error in the access phase
            if (!addr_known)
                next_state.slverr = 1'b1;
        end
    end

    // reset leaves every source off, static short filtering and normal mode
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state             <= '0;
            state.wake_enable <= RST_WAKE_EN;
            state.current_src <= RST_CURSRC;
            state.detect      <= RST_DETECT;
            state.alt_enable  <= RST_ALT_EN;
            state.mode        <= HVWK_MODE_NORMAL;
        end
        else
        begin
            state <= next_state;
        end
    end

    // =========================================================================
    // outputs
    // writes are a single access cycle; slverr for writes appears a cycle
    // late, so write errors are only reported on the registered flag
    assign PREADY         = 1'b1;
    assign PRDATA         = state.rdata;
    assign PSLVERR        = PSEL && PENABLE && state.slverr && !PWRITE;
    assign PULL_UP_EN     = state.pull_up;
    assign PULL_DOWN_EN   = state.pull_down;
    assign WAKE_INTERRUPT = state.irq;
    assign WAKE_REQUEST   = state.wake_req;

endmodule : hvwk_monitor

// >>> tb/hvwk_props.sv
`timescale 1ns/1ps
// ==================================
// checker on the top ports
module hvwk_props
    import hvwk_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [2:0]  WAKE_PIN,
    input wire logic [1:0]  ALT_OUTPUT_PIN,
    input wire logic [2:0]  PULL_UP_EN,
    input wire logic [2:0]  PULL_DOWN_EN,
    input wire logic        WAKE_INTERRUPT,
    input wire logic        WAKE_REQUEST
);
    logic [5:0]  cur;
    logic [1:0]  md;
    logic [4:0]  prv;
    logic [10:0] q [5];
    logic [10:0] qm;
    wire  [4:0]  pins = {ALT_OUTPUT_PIN, WAKE_PIN};
    wire         wr = PSEL && PENABLE && PWRITE;
    // shadow config and count quiet cycles per pin
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cur <= 6'h00;
            md <= 2'h0;
            prv <= 5'h00;
            for (int i = 0; i < 5; i++)
                q[i] <= 11'h000;
        end
        else
        begin
            if (wr && PADDR == ADDR_CURRENT_SRC)
                cur <= PWDATA[5:0];
            if (wr && PADDR == ADDR_MODE_CTRL)
                md <= PWDATA[1:0];
            prv <= pins;
            for (int i = 0; i < 5; i++)
                q[i] <= (pins[i] != prv[i]) ? 11'h000 : q[i] + {10'h000, q[i] != 11'h7ff};
        end
    end
    always_comb
    begin
        qm = 11'h000;
        for (int i = 0; i < 5; i++)
            if (q[i] > qm)
                qm = q[i];
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    AST_IRQ_MODE: assert property (md[1] && $stable(md) |-> !WAKE_INTERRUPT)
        else $error("interrupt in sleep mode");
    AST_REQ_MODE: assert property (!md[1] && $stable(md) |-> !WAKE_REQUEST)
        else $error("wake request in normal mode");
    AST_EXCL: assert property (!(WAKE_INTERRUPT && WAKE_REQUEST))
        else $error("interrupt and wake together");
    // slack of 16 covers the synchroniser and flag stages
    AST_FILTER: assert property ($rose(WAKE_INTERRUPT) && !$past(WAKE_REQUEST)
        |-> $past(qm, 8) >= FILT_SHORT_CYC - 16)
        else $error("wake without stable input");
    for (genvar i = 0; i < 3; i++)
    begin : g_pull
        wire [1:0] c = cur[2*i+:2];
        AST_PULL_NONE: assert property (c == CUR_NONE && $stable(c)
            |-> !PULL_UP_EN[i] && !PULL_DOWN_EN[i]) else $error("source not off");
        AST_PULL_DOWN: assert property (c == CUR_DOWN && $stable(c)
            |-> PULL_DOWN_EN[i] && !PULL_UP_EN[i]) else $error("pull-down wrong");
        AST_PULL_UP: assert property (c == CUR_UP && $stable(c)
            |-> PULL_UP_EN[i] && !PULL_DOWN_EN[i]) else $error("pull-up wrong");
        AST_PULL_AUTO: assert property (c == CUR_AUTO && $stable(c)
            |-> PULL_UP_EN[i] != PULL_DOWN_EN[i]) else $error("auto not one-hot");
    end
endmodule : hvwk_props

bind hvwk_monitor hvwk_props i_props (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .WAKE_PIN(WAKE_PIN), .ALT_OUTPUT_PIN(ALT_OUTPUT_PIN), .PULL_UP_EN(PULL_UP_EN),
    .PULL_DOWN_EN(PULL_DOWN_EN), .WAKE_INTERRUPT(WAKE_INTERRUPT),
    .WAKE_REQUEST(WAKE_REQUEST));

// >>> tb/hvwk_switch_model.sv
`timescale 1ns/1ps
// ==================================
// external switches, powered from a high-side output
module hvwk_switch_model
(
    input wire logic       clk,
    input wire logic [2:0] pwr,
    input wire logic [2:0] val,
    input wire logic [2:0] pu,
    input wire logic [2:0] pd,
    output logic     [2:0] pin
);
    logic [2:0] last;
    always_ff @(posedge clk)
        last <= pin;
    // unpowered switch is open: pin follows the pull, else floats and wanders
    always_comb
        for (int i = 0; i < 3; i++)
            pin[i] = pwr[i] ? val[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~last[i];
endmodule : hvwk_switch_model

// >>> tb/tb_hvwk_monitor.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_hvwk_monitor;
    import hvwk_pkg::*;
    localparam int S = FILT_SHORT_CYC + 20;
    localparam int L = FILT_LONG_CYC + 20;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwrite = 1'b0;
    logic        cw1 = 1'b0, cw2 = 1'b0, cm = 1'b0, pready, perr, irq, req, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h9233;
    logic [2:0]  pin, pu, pd, pwr, val = 3'h0;
    logic [1:0]  alt = 2'h0;
    int          error_cnt = 0;
    int          tests_run = 0;
    // sensors on pins one and two share the timer of their cyclic window
    assign pwr = cm ? {1'b1, cw2, cw1} : 3'h7;

    hvwk_monitor i_dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(perr), .WAKE_PIN(pin), .ALT_OUTPUT_PIN(alt),
        .CYCLIC_WINDOW_ONE(cw1), .CYCLIC_WINDOW_TWO(cw2), .PULL_UP_EN(pu),
        .PULL_DOWN_EN(pd), .WAKE_INTERRUPT(irq), .WAKE_REQUEST(req));
    hvwk_switch_model i_sw (.clk(clk), .pwr(pwr), .val(val), .pu(pu), .pd(pd), .pin(pin));

    initial
        forever #25 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xf
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask : rdc
    task automatic flip(input int i, input int n);
        val[i] <= ~val[i];
        cyc(n);
    endtask : flip
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        logic [1:0] c;
        cyc(5);
        nrst <= 1'b1;
        for (int k = 0; k < 7; k++)
            if (k != 4)
                rdc("reset value", 8'(k * 4), 32'h0);
        xf(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        for (int k = 0; k < 4; k++)
        begin
            c = 2'(k);
            val <= 3'(rnd());
            xf(1'b1, ADDR_CURRENT_SRC, {26'h0, c, c, c});
            cyc(S);
            `CHK("pull up", (c == CUR_UP) ? 3'h7 : (c == CUR_AUTO) ? val : 3'h0, pu)
            `CHK("pull down", (c == CUR_DOWN) ? 3'h7 : (c == CUR_AUTO) ? ~val : 3'h0, pd)
        end
        xf(1'b1, ADDR_CURRENT_SRC, 32'h15);
        for (int k = 0; k < 4; k++)
        begin
            val <= 3'(rnd());
            cyc(S);
            rdc("level", ADDR_LEVEL_STAT, {29'h0, val});
        end
        rdc("flags disabled", ADDR_WAKE_SOURCE, 32'h0);
        val <= 3'h0;
        cyc(S);
        xf(1'b1, ADDR_WAKE_ENABLE, 32'h7);
        $display("config test end");
        for (int i = 0; i < 3; i++)
            for (int k = 0; k < 2; k++)
            begin
                flip(i, FILT_SHORT_CYC / 2 + int'(rnd() % 100));
                flip(i, S);
                rdc("glitch", ADDR_WAKE_SOURCE, 32'h0);
                flip(i, S);
                rdc("edge flag", ADDR_WAKE_SOURCE, 32'h1 << i);
                `CHK("interrupt", 1'b1, irq)
                xf(1'b1, ADDR_WAKE_SOURCE, 32'h7);
                cyc(2);
                `CHK("interrupt clear", 1'b0, irq)
            end
        $display("edge test end");
        xf(1'b1, ADDR_DETECT_FILT, 32'h15);
        flip(0, S);
        rdc("long early", ADDR_WAKE_SOURCE, 32'h0);
        cyc(FILT_LONG_CYC);
        rdc("long filter", ADDR_WAKE_SOURCE, 32'h1);
        xf(1'b1, ADDR_MODE_CTRL, 32'hc);
        alt <= 2'h3;
        cyc(S);
        rdc("alt flags", ADDR_ALT_WAKE, 32'h3);
        rdc("main flags", ADDR_WAKE_SOURCE, 32'h1);
        $display("filter test end");
        xf(1'b1, ADDR_ALT_WAKE, 32'h3);
        for (int m = 0; m < 4; m++)
        begin
            xf(1'b1, ADDR_WAKE_SOURCE, 32'h7);
            xf(1'b1, ADDR_MODE_CTRL, 32'(m));
            flip(1, L);
            `CHK("mode interrupt", m < 2, irq)
            `CHK("mode wake", m > 1, req)
            rdc("mode flags", ADDR_WAKE_SOURCE, 32'h2);
            rdc("mode level", ADDR_LEVEL_STAT, (m > 1) ? 32'h0 : {29'h0, val});
        end
        $display("mode test end");
        xf(1'b1, ADDR_MODE_CTRL, 32'h0);
        val <= 3'h0;
        cyc(L);
        xf(1'b1, ADDR_WAKE_SOURCE, 32'h7);
        xf(1'b1, ADDR_DETECT_FILT, 32'he);
        cm <= 1'b1;
        val <= 3'h3;
        cyc(S);
        rdc("no window", ADDR_WAKE_SOURCE, 32'h0);
        cw1 <= 1'b1;
        cyc(S);
        cw1 <= 1'b0;
        cyc(8);
        rdc("window one", ADDR_WAKE_SOURCE, 32'h1);
        xf(1'b0, ADDR_LEVEL_STAT, 32'h0);
        `CHK("held level", 1'b1, rd[0])
        cw2 <= 1'b1;
        cyc(S);
        cw2 <= 1'b0;
        cyc(8);
        rdc("window two", ADDR_WAKE_SOURCE, 32'h3);
        $display("cyclic test end");
        close_out();
    end

    initial
    begin
        cyc(40000);
        error_cnt++;
        close_out();
    end
endmodule : tb_hvwk_monitor
